// *** hdl/sbs_defines.svh ***
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// =====================================================================
// geometry
`define SBS_ADDR_W 14
`define SBS_DATA_W 64
`define SBS_LANES 8
`define SBS_LANE_W 8
`define SBS_BURST_W 2
`define SBS_FIFO_DEPTH 8

// =====================================================================
// reset values, burst step and lane masks
`define SBS_STEP_RST 2'h0
`define SBS_STEP_ONE 2'h1
`define SBS_LANES_NONE 8'h00
`define SBS_LANES_ALL 8'hFF
`define SBS_STRAP_RST 2'h0

// =====================================================================
// strap bit positions
`define SBS_STRAP_ORDER 0
`define SBS_STRAP_MODE 1

`endif

// *** hdl/sbs_pkg.sv ***
`include "sbs_defines.svh"

package sbs_pkg;
    typedef enum logic {
        BURST_LINEAR,
        BURST_INTERLEAVED
    } burst_order_e;

    typedef enum logic {
        OUT_FLOW_THROUGH,
        OUT_REGISTERED
    } output_mode_e;

    typedef enum logic {
        ACC_IDLE,
        ACC_BURST
    } access_state_e;

    typedef logic [`SBS_LANES-1:0] lane_mask_t;
endpackage

// *** hdl/sbs_write_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_write_fifo #(
    parameter int WIDTH = 86,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    // =================================================================
    // full when the pointers differ only in the wrap bit
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = store[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

`default_nettype wire

// *** hdl/sync_burst_sram_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"

module sync_burst_sram_control #(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int DATA_W = `SBS_DATA_W,
    parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic output_enable_n_i,
    input wire logic select_primary_n_i,
    input wire logic select_depth_a_n_i,
    input wire logic select_depth_b_n_i,
    input wire logic select_depth_c_i,
    input wire logic select_depth_d_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic burst_step_n_i,
    input wire logic global_write_n_i,
    input wire logic byte_write_qualifier_n_i,
    input wire logic [`SBS_LANES-1:0] byte_lane_write_sel_n_i,
    input wire logic burst_order_strap_i,
    input wire logic output_mode_strap_i,
    input wire logic drain_hold_i,
    output logic write_ready_o,
    output logic write_dropped_o,
    output logic burst_active_o
);
    import sbs_pkg::*;

    localparam int ENTRY_W = ADDR_W + `SBS_LANES + DATA_W;
    localparam int WORDS = 1 << ADDR_W;

    // =================================================================
    // decoding shared by the access path

    // low address bits for a given step of the burst
    function automatic logic [`SBS_BURST_W-1:0] burst_low(
        input burst_order_e order,
        input logic [`SBS_BURST_W-1:0] start,
        input logic [`SBS_BURST_W-1:0] step
    );
        logic [`SBS_BURST_W-1:0] lo;
        lo = start + step;
        if (order == BURST_INTERLEAVED) begin
            lo = start ^ step;
        end
        return lo;
    endfunction

    // byte lanes that a write at this edge touches
    function automatic lane_mask_t lane_write_mask(
        input logic global_n,
        input logic qualifier_n,
        input logic [`SBS_LANES-1:0] sel_n
    );
        lane_mask_t mask;
        mask = `SBS_LANES_NONE;
        if (!global_n) begin
            mask = `SBS_LANES_ALL;
        end else if (!qualifier_n) begin
            mask = ~sel_n;
        end
        return mask;
    endfunction

    // =================================================================
    // strap synchronisers: straps are static pins, taken when stages agree
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_s3;
    logic [1:0] strap;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_s1 <= `SBS_STRAP_RST;
            strap_s2 <= `SBS_STRAP_RST;
            strap_s3 <= `SBS_STRAP_RST;
        end else begin
            strap_s1 <= {output_mode_strap_i, burst_order_strap_i};
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap <= `SBS_STRAP_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (strap_s2[i] == strap_s3[i]) begin
                    strap[i] <= strap_s3[i];
                end
            end
        end
    end

    burst_order_e order;
    output_mode_e out_mode;
    assign order = strap[`SBS_STRAP_ORDER] ? BURST_INTERLEAVED : BURST_LINEAR;
    assign out_mode = strap[`SBS_STRAP_MODE] ? OUT_REGISTERED : OUT_FLOW_THROUGH;

    // =================================================================
    // access decode on the pins as they stand at the edge
    access_state_e state;
    logic [ADDR_W-1:`SBS_BURST_W] addr_high;
    logic [`SBS_BURST_W-1:0] start_low;
    logic [`SBS_BURST_W-1:0] step;
    logic all_selected;
    logic proc_strobe;
    logic any_strobe;
    logic load;
    logic deselect;
    logic advance;
    logic access;
    lane_mask_t lanes;
    logic write_now;
    logic read_now;
    logic [`SBS_BURST_W-1:0] next_step;
    logic [ADDR_W-1:0] access_addr;

    assign all_selected = !select_primary_n_i && !select_depth_a_n_i
        && !select_depth_b_n_i
        && select_depth_c_i && select_depth_d_i;
    assign proc_strobe = !processor_addr_strobe_n_i && !select_primary_n_i;
    // controller strobe only matters when the processor strobe is not taken
    assign any_strobe = proc_strobe || !controller_addr_strobe_n_i;
    assign load = any_strobe && all_selected;
    assign deselect = any_strobe && !all_selected;
    assign advance = !burst_step_n_i && !any_strobe && (state == ACC_BURST);
    assign access = load || ((state == ACC_BURST) && !any_strobe);
    assign lanes = lane_write_mask(global_write_n_i, byte_write_qualifier_n_i,
        byte_lane_write_sel_n_i);
    // a processor-strobe start is always a read whatever the write pins say
    assign write_now = access && (lanes != `SBS_LANES_NONE) && !(load && proc_strobe);
    assign read_now = access && !write_now;
    assign next_step = advance ? (step + `SBS_STEP_ONE) : step;

    always_comb begin
        access_addr = {addr_high, burst_low(order, start_low, next_step)};
        if (load) begin
            access_addr = addr_i;
        end
    end

    // =================================================================
    // address register and burst counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ACC_IDLE;
        end else if (load) begin
            state <= ACC_BURST;
        end else if (deselect) begin
            state <= ACC_IDLE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_high <= '0;
            start_low <= `SBS_STEP_RST;
        end else if (load) begin
            addr_high <= addr_i[ADDR_W-1:`SBS_BURST_W];
            start_low <= addr_i[`SBS_BURST_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step <= `SBS_STEP_RST;
        end else if (load) begin
            step <= `SBS_STEP_RST;
        end else begin
            step <= next_step;
        end
    end

    assign burst_active_o = (state == ACC_BURST);

    // =================================================================
    // write path: captured words queue up, then land in the array
    logic [ENTRY_W-1:0] entry_in;
    logic [ENTRY_W-1:0] entry_out;
    logic entry_valid;
    logic drain;

    // data and lane mask are registered into the queue at this edge
    assign entry_in = {access_addr, lanes, dq_i};

    sbs_write_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) write_queue (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(write_now),
        .in_ready_o(write_ready_o),
        .in_data_i(entry_in),
        .out_valid_o(entry_valid),
        .out_ready_i(drain),
        .out_data_o(entry_out)
    );

    assign drain = entry_valid && !drain_hold_i;

    // a write arriving on a full queue cannot stall the bus, so it is flagged
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            write_dropped_o <= 1'b0;
        end else begin
            write_dropped_o <= write_now && !write_ready_o;
        end
    end

    // =================================================================
    // storage array
    logic [DATA_W-1:0] mem [0:WORDS-1];
    logic [ADDR_W-1:0] drain_addr;
    lane_mask_t drain_lanes;
    logic [DATA_W-1:0] drain_data;

    assign drain_addr = entry_out[ENTRY_W-1 -: ADDR_W];
    assign drain_lanes = entry_out[DATA_W +: `SBS_LANES];
    assign drain_data = entry_out[DATA_W-1:0];

    // lanes left unselected keep their old contents
    always_ff @(posedge clk_i) begin
        if (drain) begin
            for (int n = 0; n < `SBS_LANES; n++) begin
                if (drain_lanes[n]) begin
                    mem[drain_addr][n*`SBS_LANE_W +: `SBS_LANE_W] <=
                        drain_data[n*`SBS_LANE_W +: `SBS_LANE_W];
                end
            end
        end
    end

    // =================================================================
    // read path: one flop for flow-through, one more for registered mode
    logic [DATA_W-1:0] read_stage;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            read_stage <= '0;
        end else if (read_now) begin
            read_stage <= mem[access_addr];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_o <= '0;
        end else if (out_mode == OUT_REGISTERED) begin
            dq_o <= read_stage;
        end else if (read_now) begin
            dq_o <= mem[access_addr];
        end
    end

    // =================================================================
    // driver enables
    logic read_enable;
    logic read_enable_dly;
    logic write_seen;
    logic drive;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            read_enable <= 1'b0;
            read_enable_dly <= 1'b0;
        end else begin
            read_enable <= read_now;
            read_enable_dly <= read_enable && read_now;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            write_seen <= 1'b0;
        end else begin
            write_seen <= write_now;
        end
    end

    // the delayed enable keeps the first clock of a registered access quiet
    assign drive = (out_mode == OUT_REGISTERED) ? read_enable_dly : read_enable;
    // output enable acts without the clock; writes win over it either way
    assign dq_oe_o = !output_enable_n_i && drive
        && !write_seen && !write_now;
endmodule

`default_nettype wire

// *** test/sbs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// cache controller side of the shared data lines
module sbs_host_model (
    input wire logic clk_i,
    input wire logic drive_i,
    input wire logic oe_req_n_i,
    input wire logic [63:0] wdata_i,
    input wire logic [63:0] dev_data_i,
    input wire logic dev_oe_i,
    input wire logic keep_oe_i,
    output logic [63:0] line_o,
    output logic output_enable_n_o
);
    logic [63:0] last;
    // enable is lifted whenever write data goes out, so the lines never fight;
    // a test may keep it low to provoke a clash that the device must refuse
    assign output_enable_n_o = oe_req_n_i || (drive_i && !keep_oe_i);
    always_ff @(posedge clk_i) begin
        last <= line_o;
    end
    // floating lines show the inverse of the last level so stale data never matches
    assign line_o = drive_i ? wdata_i : (dev_oe_i ? dev_data_i : ~last);
endmodule
`default_nettype wire

// *** test/sbs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// port checks
module sbs_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dq_oe_o,
    input wire logic output_enable_n_i,
    input wire logic select_primary_n_i,
    input wire logic select_depth_a_n_i,
    input wire logic select_depth_b_n_i,
    input wire logic select_depth_c_i,
    input wire logic select_depth_d_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic global_write_n_i,
    input wire logic output_mode_strap_i,
    input wire logic drain_hold_i,
    input wire logic write_ready_o,
    input wire logic write_dropped_o,
    input wire logic burst_active_o
);
    logic sel_all;
    logic strobe;
    assign sel_all = !select_primary_n_i && !select_depth_a_n_i && !select_depth_b_n_i
        && select_depth_c_i && select_depth_d_i;
    assign strobe = !processor_addr_strobe_n_i || !controller_addr_strobe_n_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_oe_masks_drivers: assert property (output_enable_n_i |-> !dq_oe_o)
        else $error("drivers on with output enable high");
    a_write_quiets_bus: assert property (
        (!controller_addr_strobe_n_i && processor_addr_strobe_n_i && sel_all && !global_write_n_i)
        |-> !dq_oe_o ##1 !dq_oe_o) else $error("drivers on around a write");
    a_select_opens: assert property (strobe && sel_all |=> burst_active_o)
        else $error("selected strobe did not open a burst");
    a_deselect_closes: assert property (
        !controller_addr_strobe_n_i && !sel_all |=> !burst_active_o)
        else $error("unselected strobe left burst open");
    a_primary_masks: assert property (
        !processor_addr_strobe_n_i && select_primary_n_i && controller_addr_strobe_n_i
        |=> burst_active_o == $past(burst_active_o)) else $error("masked strobe changed burst");
    a_first_clock_quiet: assert property (
        !burst_active_o && !processor_addr_strobe_n_i && sel_all && output_mode_strap_i
        && $past(output_mode_strap_i, 4) |=> !dq_oe_o) else $error("drivers on in first clock");
    a_drop_needs_full: assert property (write_dropped_o |-> !$past(write_ready_o))
        else $error("write dropped while queue had room");
    a_hold_stays_full: assert property (
        drain_hold_i && !write_ready_o |=> !write_ready_o) else $error("stalled queue drained");
endmodule
bind sync_burst_sram_control sbs_properties props (.*);
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, proc_n = 1'b1, ctrl_n = 1'b1, adv_n = 1'b1;
    logic gw_n = 1'b1, bq_n = 1'b1, order = 1'b0, mode = 1'b0, hold = 1'b0, keep_oe = 1'b0;
    logic oe_req_n = 1'b0, wdrv = 1'b0, dq_oe, oe_n, ready, dropped, active;
    logic [7:0] lane_n = 8'hFF;
    logic [4:0] sv = 5'h00, nsel = 5'h00;
    logic [13:0] addr = 14'h0000;
    logic [63:0] wdata = 64'h0, dq_in, dq_out;
    logic [63:0] ref_mem [logic [13:0]];
    int error_cnt = 0;
    int samples_checked = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    sync_burst_sram_control dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .dq_i(dq_in),
        .dq_o(dq_out), .dq_oe_o(dq_oe), .output_enable_n_i(oe_n), .select_primary_n_i(sv[0]),
        .select_depth_a_n_i(sv[1]), .select_depth_b_n_i(sv[2]), .select_depth_c_i(!sv[3]),
        .select_depth_d_i(!sv[4]), .processor_addr_strobe_n_i(proc_n),
        .controller_addr_strobe_n_i(ctrl_n), .burst_step_n_i(adv_n), .global_write_n_i(gw_n),
        .byte_write_qualifier_n_i(bq_n), .byte_lane_write_sel_n_i(lane_n),
        .burst_order_strap_i(order), .output_mode_strap_i(mode), .drain_hold_i(hold),
        .write_ready_o(ready), .write_dropped_o(dropped), .burst_active_o(active));
    sbs_host_model host (.clk_i(clk_i), .drive_i(wdrv), .oe_req_n_i(oe_req_n),
        .wdata_i(wdata), .dev_data_i(dq_out), .dev_oe_i(dq_oe), .line_o(dq_in),
        .output_enable_n_o(oe_n), .keep_oe_i(keep_oe));
    // =====================================================================
    // bench helpers
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic drv(input logic p, c, v, g, q, input logic [7:0] s, input logic [13:0] a,
        input logic [63:0] d);
        @(posedge clk_i);
        proc_n <= p;
        ctrl_n <= c;
        adv_n <= v;
        gw_n <= g;
        bq_n <= q;
        lane_n <= s;
        addr <= a;
        wdata <= d;
        wdrv <= !g || !q;
        sv <= nsel;
    endtask
    task automatic settle();
        drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, 14'h0000, 64'h0);
        repeat (3) @(posedge clk_i);
    endtask
    // controller-strobe write, finished in one clock
    task automatic wr(input logic [13:0] a, input logic [63:0] d, input logic g, q,
        input logic [7:0] s);
        drv(1'b1, 1'b0, 1'b1, g, q, s, a, d);
        for (int n = 0; n < 8; n++) begin
            if (nsel == 5'h00 && (!g || (!q && !s[n]))) begin
                ref_mem[a][8*n +: 8] = d[8*n +: 8];
            end
        end
    endtask
    // =====================================================================
    // scenarios
    task automatic rd_burst(input logic [13:0] a, input logic ord, input logic md);
        logic [1:0] k;
        logic [13:0] ea;
        nsel = 5'h01;
        drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, a, 64'h0);
        drv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'hFF, a, 64'h0);
        nsel = 5'h00;
        order <= ord;
        mode <= md;
        settle();
        repeat (2) @(posedge clk_i);
        drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, a, 64'h0);
        for (int i = 0; i < 5; i++) begin
            drv(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'hFF, 14'h0000, 64'h0);
            oe_req_n <= (i == 2);
            @(negedge clk_i);
            k = 2'(md ? i - 1 : i);
            ea = {a[13:2], ord ? a[1:0] ^ k : a[1:0] + k};
            if (!md || i > 0) chk("read data", dq_out, ref_mem[ea]);
            if (i == 0) chk("first clock drive", 64'(dq_oe), 64'(!md));
            if (i == 1) chk("drivers on", 64'(dq_oe), 64'h1);
            if (i == 2) chk("drivers off", 64'(dq_oe), 64'h0);
        end
        settle();
        oe_req_n <= 1'b0;
    endtask
    task automatic t_lanes();
        for (int n = 0; n < 8; n++) begin
            wr(14'h0014, {8{8'(8'h30 + n)}}, 1'b1, 1'b0, ~(8'h01 << n));
        end
        wr(14'h0014, 64'h0, 1'b1, 1'b1, 8'h00);
        wr(14'h0015, 64'h0123_4567_89AB_CDEF, 1'b0, 1'b1, 8'hFF);
        wr(14'h0016, 64'hFEDC_BA98_7654_3210, 1'b0, 1'b0, 8'hFE);
        settle();
        rd_burst(14'h0014, 1'b0, 1'b0);
    endtask
    task automatic t_selects();
        for (int i = 0; i < 5; i++) begin
            nsel = 5'(1 << i);
            wr(14'h0017, 64'h0, 1'b0, 1'b1, 8'hFF);
        end
        nsel = 5'h00;
        settle();
        rd_burst(14'h0017, 1'b1, 1'b0);
    endtask
    // processor strobe: write pins ignored on the start edge, acted on at the next
    task automatic t_proc_write(input logic [13:0] a, input logic [63:0] d, input logic g);
        drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'hFF, a, ~d);
        drv(1'b1, 1'b1, 1'b1, g, 1'b1, 8'hFF, a, d);
        if (!g) ref_mem[a] = d;
        settle();
    endtask
    // output enable stays low while write data goes out: the write alone must quiet the pins
    task automatic t_write_guard(input logic [13:0] a, input logic [63:0] d);
        keep_oe <= 1'b1;
        drv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'hFF, a, 64'h0);
        drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, a, 64'h0);
        drv(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'hFF, a, d);
        ref_mem[a] = d;
        @(negedge clk_i);
        chk("drivers during write", 64'(dq_oe), 64'h0);
        settle();
        keep_oe <= 1'b0;
        rd_burst(a, 1'b1, 1'b0);
    endtask
    task automatic t_fill();
        @(posedge clk_i);
        hold <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(14'h0024 + 14'(i), {8{8'h77}}, 1'b0, 1'b1, 8'hFF);
        end
        drv(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'hFF, 14'h0028, 64'h0);
        drv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, 14'h0000, 64'h0);
        @(negedge clk_i);
        chk("queue ready", 64'(ready), 64'h0);
        chk("write dropped", 64'(dropped), 64'h1);
        @(posedge clk_i);
        hold <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk("queue ready", 64'(ready), 64'h1);
        rd_burst(14'h0024, 1'b1, 1'b1);
        rd_burst(14'h0028, 1'b0, 1'b0);
        rd_burst(14'h002C, 1'b0, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < 32; i++) begin
            wr(14'h0010 + 14'(i), {8{8'(i)}} ^ 64'hA5C3_0F96_5A3C_F069, 1'b0, 1'b1, 8'hFF);
        end
        settle();
        t_lanes();
        t_selects();
        t_proc_write(14'h0018, 64'h1357_9BDF_2468_ACE0, 1'b1);
        t_proc_write(14'h0019, 64'h0F0F_F0F0_3C3C_C3C3, 1'b0);
        rd_burst(14'h0018, 1'b0, 1'b1);
        t_write_guard(14'h001C, 64'h2468_ACE0_1357_9BDF);
        for (int m = 0; m < 4; m++) begin
            rd_burst(14'h0011 + 14'(2 * m[0]), m[1], m[0]);
        end
        t_fill();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
